// >>> verilog/sdi_ctrl.sv
// Memory controller end: request FIFO, init sequencer and access engine

// Request FIFO; DEPTH must be a power of two
module sdi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH]; // Storage words
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Fill level
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign o_data = mem_q[rp_r];
  // Storage write
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_r] <= i_data;
    end
  end
  // Pointers, level and registered full/empty flags
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      o_ready <= 1'b0;
      o_valid <= 1'b0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      o_ready <= (cnt_nxt != (AW+1)'(DEPTH));
      o_valid <= (cnt_nxt != '0);
    end
  end
endmodule

module sdi_ctrl #(
  parameter int STARTUP_CYC = sdi_pkg::STARTUP_CYC,
  parameter int N_REF = sdi_pkg::REF_COUNT,
  parameter bit REF_AFTER_LMR = 1'b0,
  parameter int FIFO_DEPTH = sdi_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  sdi_if.ctrl bus,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [sdi_pkg::BANK_W-1:0] i_req_bank,
  input wire logic [sdi_pkg::ADDR_W-1:0] i_req_row,
  input wire logic [sdi_pkg::COL_W-1:0] i_req_col,
  input wire logic [sdi_pkg::DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [sdi_pkg::DATA_W-1:0] o_rd_data,
  output logic o_init_done
);
  sdi_pkg::sdi_st_t state_r; // Sequencer state
  sdi_pkg::sdi_st_t state_nxt;
  logic [15:0] cnt_r; // Wait counter
  logic [15:0] cnt_nxt;
  logic [7:0] ref_r; // Refreshes issued so far
  logic [7:0] ref_nxt;
  logic cke_r; // Clock enable to the memory
  logic [3:0] cmd_r; // Registered command
  logic [3:0] cmd_nxt;
  logic [sdi_pkg::BANK_W-1:0] bank_r; // Registered bank select
  logic [sdi_pkg::BANK_W-1:0] bank_nxt;
  logic [sdi_pkg::ADDR_W-1:0] addr_r; // Registered address
  logic [sdi_pkg::ADDR_W-1:0] addr_nxt;
  logic dq_oe_r; // Write data drive enable
  logic [sdi_pkg::DATA_W-1:0] dq_o_r; // Write data
  logic wdrv_nxt;
  logic f_valid; // FIFO has a request
  logic f_pop; // Take request from FIFO
  logic [sdi_pkg::REQ_W-1:0] f_data;
  logic [sdi_pkg::REQ_W-1:0] req_r; // Request being served
  logic req_wr;
  logic [sdi_pkg::BANK_W-1:0] req_bank;
  logic [sdi_pkg::ADDR_W-1:0] req_row;
  logic [sdi_pkg::COL_W-1:0] req_col;
  logic [sdi_pkg::DATA_W-1:0] req_data;
  assign {req_wr, req_bank, req_row, req_col, req_data} = req_r;

  // Pin drive, all from flip-flops
  assign bus.clk_en = cke_r;
  assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_r;
  assign {bus.bank_select_high, bus.bank_select_low} = bank_r;
  assign bus.row_column_address_bits = addr_r;
  assign bus.ctrl_dq_o = dq_o_r;
  assign bus.ctrl_dq_oe = dq_oe_r;

  // Request FIFO; a full FIFO drops o_req_ready back to the user
  sdi_fifo #(
    .W(sdi_pkg::REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(i_req_valid),
    .o_ready(o_req_ready),
    .i_data({i_req_write, i_req_bank, i_req_row, i_req_col, i_req_wdata}),
    .o_valid(f_valid),
    .i_ready(f_pop),
    .o_data(f_data)
  );

  // Next state, next command and wait loads
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
    ref_nxt = ref_r;
    cmd_nxt = sdi_pkg::CMD_NOP;
    bank_nxt = '0;
    addr_nxt = '0;
    wdrv_nxt = 1'b0;
    f_pop = 1'b0;
    case (state_r)
      sdi_pkg::ST_POWERUP: begin
        // Only inhibit/NO_OPERATION_CMD until the start-up wait is over
        cmd_nxt = cke_r ? sdi_pkg::CMD_NOP : sdi_pkg::CMD_INHIBIT;
        if (cnt_r == 16'h0000) begin
          state_nxt = sdi_pkg::ST_PRE_ALL;
        end
      end
      sdi_pkg::ST_PRE_ALL: begin
        // Close every bank with the all-banks bit set
        cmd_nxt = sdi_pkg::CMD_PRE;
        addr_nxt[sdi_pkg::ALL_BANKS_POS] = 1'b1;
        cnt_nxt = 16'(sdi_pkg::TRP_CYC - 1);
        state_nxt = sdi_pkg::ST_WAIT_RP;
      end
      sdi_pkg::ST_WAIT_RP: begin
        // NOPs through the precharge period
        if (cnt_r == 16'h0000) begin
          state_nxt = REF_AFTER_LMR ? sdi_pkg::ST_LMR : sdi_pkg::ST_REF;
        end
      end
      sdi_pkg::ST_REF: begin
        // One refresh per pass, repeated N_REF times
        cmd_nxt = sdi_pkg::CMD_REF;
        ref_nxt = ref_r + 8'h01;
        cnt_nxt = 16'(sdi_pkg::REFRESH_CYCLE_PERIOD_CYC - 1);
        state_nxt = sdi_pkg::ST_WAIT_RFC;
      end
      sdi_pkg::ST_WAIT_RFC: begin
        // NOPs through the refresh cycle period, then loop or move on
        if (cnt_r == 16'h0000) begin
          if (ref_r < 8'(N_REF)) begin
            state_nxt = sdi_pkg::ST_REF;
          end else if (REF_AFTER_LMR) begin
            state_nxt = sdi_pkg::ST_IDLE;
          end else begin
            state_nxt = sdi_pkg::ST_LMR;
          end
        end
      end
      sdi_pkg::ST_LMR: begin
        // Banks are all idle here; bank bits forced to zero
        cmd_nxt = sdi_pkg::CMD_LMR;
        addr_nxt = sdi_pkg::CTRL_MODE;
        cnt_nxt = 16'(sdi_pkg::MODE_LOAD_DELAY_CYC - 1);
        state_nxt = sdi_pkg::ST_WAIT_MRD;
      end
      sdi_pkg::ST_WAIT_MRD: begin
        // NOPs through the mode load delay
        if (cnt_r == 16'h0000) begin
          state_nxt = REF_AFTER_LMR ? sdi_pkg::ST_REF : sdi_pkg::ST_IDLE;
        end
      end
      sdi_pkg::ST_IDLE: begin
        // Take next request
        if (f_valid) begin
          f_pop = 1'b1;
          state_nxt = sdi_pkg::ST_ACT;
        end
      end
      sdi_pkg::ST_ACT: begin
        // Open the row first
        cmd_nxt = sdi_pkg::CMD_ACT;
        bank_nxt = req_bank;
        addr_nxt = req_row;
        cnt_nxt = 16'(sdi_pkg::TRCD_CYC - 1);
        state_nxt = sdi_pkg::ST_WAIT_RCD;
      end
      sdi_pkg::ST_WAIT_RCD: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = sdi_pkg::ST_RW;
        end
      end
      sdi_pkg::ST_RW: begin
        // Column command without auto precharge; write data goes with it
        cmd_nxt = req_wr ? sdi_pkg::CMD_WR : sdi_pkg::CMD_RD;
        bank_nxt = req_bank;
        addr_nxt = {3'h0, req_col};
        wdrv_nxt = req_wr;
        cnt_nxt = req_wr ? 16'(sdi_pkg::TWR_CYC - 1) : 16'(sdi_pkg::CTRL_CL + 1);
        state_nxt = sdi_pkg::ST_WAIT_DATA;
      end
      sdi_pkg::ST_WAIT_DATA: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = sdi_pkg::ST_PRE;
        end
      end
      sdi_pkg::ST_PRE: begin
        // Close only the bank used
        cmd_nxt = sdi_pkg::CMD_PRE;
        bank_nxt = req_bank;
        addr_nxt[sdi_pkg::ALL_BANKS_POS] = 1'b0;
        cnt_nxt = 16'(sdi_pkg::TRP_CYC - 1);
        state_nxt = sdi_pkg::ST_WAIT_PRE;
      end
      sdi_pkg::ST_WAIT_PRE: begin
        if (cnt_r == 16'h0000) begin
          state_nxt = sdi_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = sdi_pkg::ST_POWERUP;
      end
    endcase
  end

  // Sequencer state, wait counter and refresh count
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= sdi_pkg::ST_POWERUP;
      cnt_r <= 16'(STARTUP_CYC - 1);
      ref_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ref_r <= ref_nxt;
    end
  end

  // Clock enable: low from reset, high from mid start-up onward
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cke_r <= 1'b0;
    end else if (state_r != sdi_pkg::ST_POWERUP || cnt_r < 16'(STARTUP_CYC / 2)) begin
      cke_r <= 1'b1;
    end
  end

  // Command, address and write data registers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cmd_r <= sdi_pkg::CMD_INHIBIT;
      bank_r <= '0;
      addr_r <= '0;
      dq_oe_r <= 1'b0;
      dq_o_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      dq_oe_r <= wdrv_nxt;
      dq_o_r <= req_data;
    end
  end

  // Request latch
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_r <= '0;
    end else if (f_pop) begin
      req_r <= f_data;
    end
  end

  // Read data capture at the end of the latency wait
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      o_rd_valid <= (state_r == sdi_pkg::ST_WAIT_DATA) && (cnt_r == 16'h0000) && !req_wr;
      if ((state_r == sdi_pkg::ST_WAIT_DATA) && (cnt_r == 16'h0000) && !req_wr) begin
        o_rd_data <= bus.dq;
      end
    end
  end

  // Init done flag, sticky once idle is first reached
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_init_done <= 1'b0;
    end else if (state_nxt == sdi_pkg::ST_IDLE) begin
      o_init_done <= 1'b1;
    end
  end
endmodule

// >>> verilog/sdi_pkg.sv
// Shared constants, command codes and state type for the SDRAM link
package sdi_pkg;
  // Clock period of the system clock in ns (10 MHz)
  localparam int CLK_PERIOD_NS = 100;
  // Round a least time up to whole cycles, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  // Start-up wait in us and its cycle count
  localparam int T_STARTUP_US = 100;
  localparam int STARTUP_CYC = ns2cyc(T_STARTUP_US * 1000);
  // Clock enable rises halfway through the start-up wait
  localparam int CKE_RISE_CYC = STARTUP_CYC / 2;
  // Precharge period, refresh cycle period, mode load delay
  localparam int T_RP_NS = 20;
  localparam int T_RFC_NS = 70;
  localparam int T_MRD_NS = 20;
  // Activate to read/write delay and write recovery
  localparam int T_RCD_NS = 20;
  localparam int T_WR_NS = 20;
  localparam int TRP_CYC = ns2cyc(T_RP_NS);
  localparam int REFRESH_CYCLE_PERIOD_CYC = ns2cyc(T_RFC_NS);
  localparam int MODE_LOAD_DELAY_CYC = ns2cyc(T_MRD_NS);
  localparam int TRCD_CYC = ns2cyc(T_RCD_NS);
  localparam int TWR_CYC = ns2cyc(T_WR_NS);
  // Number of refresh cycles during initialisation
  localparam int REF_COUNT = 2;
  // Link widths
  localparam int BANK_W = 2;
  localparam int ADDR_W = 11;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  // Address bit that selects all banks on precharge
  localparam int ALL_BANKS_POS = 10;
  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_INHIBIT = 4'hF;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;
  // Mode register fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_POS = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_POS = 9;
  localparam logic [2:0] BL_FULL = 3'h7;
  // Mode the memory holds if never programmed
  localparam logic [10:0] MODE_DEFAULT = 11'h020;
  // Mode the controller programs: burst of one, sequential, latency 3
  localparam logic [10:0] CTRL_MODE = 11'h030;
  localparam int CTRL_CL = 3;
  // Request FIFO depth and request word width
  localparam int FIFO_DEPTH = 16;
  localparam int REQ_W = 1 + BANK_W + ADDR_W + COL_W + DATA_W;
  // Controller states
  typedef enum logic [3:0] {
    ST_POWERUP, ST_PRE_ALL, ST_WAIT_RP, ST_REF, ST_WAIT_RFC, ST_LMR,
    ST_WAIT_MRD, ST_IDLE, ST_ACT, ST_WAIT_RCD, ST_RW, ST_WAIT_DATA,
    ST_PRE, ST_WAIT_PRE
  } sdi_st_t;
endpackage

// >>> verilog/sdi_if.sv
// Interface joining the memory controller and the memory device
interface sdi_if;
  // Clock enable and command pins
  logic clk_en;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  // Bank select and address
  logic bank_select_low;
  logic bank_select_high;
  logic [sdi_pkg::ADDR_W-1:0] row_column_address_bits;
  // Data bus, one driver pair per end
  logic [sdi_pkg::DATA_W-1:0] ctrl_dq_o;
  logic ctrl_dq_oe;
  logic [sdi_pkg::DATA_W-1:0] mem_dq_o;
  logic mem_dq_oe;
  logic [sdi_pkg::DATA_W-1:0] dq;
  // Resolved bus level; undriven bus reads as zero
  assign dq = mem_dq_oe ? mem_dq_o : (ctrl_dq_oe ? ctrl_dq_o : '0);
  modport ctrl (
    output clk_en, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    output row_column_address_bits, ctrl_dq_o, ctrl_dq_oe,
    input dq
  );
  modport mem (
    input clk_en, cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high,
    input row_column_address_bits, dq,
    output mem_dq_o, mem_dq_oe
  );
endinterface

// >>> verilog/sdi_mem.sv
// Memory device end: command decode, bank state, mode register, bursts
module sdi_mem #(
  parameter logic [10:0] MODE_DEFAULT = sdi_pkg::MODE_DEFAULT,
  parameter int MRD_CYC = sdi_pkg::MODE_LOAD_DELAY_CYC,
  parameter int MEM_AW = 12
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  sdi_if.mem bus,
  output logic o_ready,
  output logic o_banks_idle,
  output logic [sdi_pkg::ADDR_W-1:0] o_mode
);
  logic [3:0] cmd; // Command code from the pins
  logic cmd_on; // Clock enabled and chip selected
  logic [1:0] bank;
  logic [sdi_pkg::ADDR_W-1:0] addr;
  logic is_act;
  logic is_pre;
  logic is_lmr;
  logic is_acc; // Read or write to an open bank
  logic [3:0] open_r; // Bank open flags
  logic [3:0] open_nxt;
  logic [sdi_pkg::ADDR_W-1:0] row_q [4]; // Open row per bank
  logic [7:0] mrd_r; // Mode load delay counter
  logic [sdi_pkg::DATA_W-1:0] mem_q [2**MEM_AW]; // Stored words
  logic bst_act_r; // Burst in progress
  logic bst_wr_r;
  logic [1:0] bst_bank_r;
  logic [7:0] bst_start_r;
  logic [8:0] bst_idx_r;
  logic [8:0] bst_len_r;
  logic [8:0] bl_len; // Burst length from mode
  logic beat_v;
  logic beat_wr;
  logic [1:0] beat_bank;
  logic [7:0] beat_start;
  logic [8:0] beat_i;
  logic [8:0] beat_len;
  logic [7:0] mask;
  logic [7:0] offs;
  logic [7:0] beat_col;
  logic [MEM_AW-1:0] idx;
  logic [2:0] rp_v_r; // Read pipe valid per stage
  logic [sdi_pkg::DATA_W-1:0] rp_d_r [3]; // Read pipe data
  logic [1:0] cl_sel; // Pipe stage matching the latency
  logic [2:0] cl;
  logic [sdi_pkg::ADDR_W-1:0] mode_q; // Mode register
  logic mrd_done_r; // A mode load has been seen

  // Inputs are taken at the rising edge only
  assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  assign cmd_on = bus.clk_en && !bus.cs_n;
  assign bank = {bus.bank_select_high, bus.bank_select_low};
  assign addr = bus.row_column_address_bits;
  assign is_lmr = cmd_on && (cmd == sdi_pkg::CMD_LMR);
  assign is_pre = cmd_on && (cmd == sdi_pkg::CMD_PRE);
  // Operational commands only once the mode load delay is over
  assign is_act = cmd_on && o_ready && (cmd == sdi_pkg::CMD_ACT);
  assign is_acc = cmd_on && o_ready && open_r[bank] &&
                  (cmd == sdi_pkg::CMD_RD || cmd == sdi_pkg::CMD_WR);
  // Mode register shown as it stands
  assign o_mode = mode_q;
  assign cl = mode_q[sdi_pkg::MODE_CL_LSB +: 3];
  assign cl_sel = (cl == 3'h0 || cl > 3'h3) ? 2'h0 : 2'(cl - 3'h1);

  // Bank open flags
  always_comb begin
    open_nxt = open_r;
    if (is_pre && addr[sdi_pkg::ALL_BANKS_POS]) begin
      open_nxt = 4'h0;
    end else if (is_pre) begin
      open_nxt[bank] = 1'b0;
    end else if (is_act) begin
      open_nxt[bank] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      open_r <= 4'h0;
      o_banks_idle <= 1'b1;
    end else begin
      open_r <= open_nxt;
      o_banks_idle <= (open_nxt == 4'h0);
    end
  end

  // Row latch on activate: all 11 address bits kept, but only the low 2 reach the 12-bit word index
  always_ff @(posedge i_clk) begin
    if (is_act) begin
      row_q[bank] <= addr;
    end
  end

  // Mode register keeps its value until the next load
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= MODE_DEFAULT;
    end else if (is_lmr) begin
      mode_q <= addr;
    end
  end

  // Ready after the mode load delay
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_ready <= 1'b0;
      mrd_r <= 8'h00;
    end else if (is_lmr) begin
      o_ready <= 1'b0;
      mrd_r <= 8'(MRD_CYC - 1);
    end else if (mrd_r != 8'h00) begin
      mrd_r <= mrd_r - 8'h01;
    end else begin
      // Delay over: ready only if a mode load has happened
      o_ready <= o_ready | mrd_done_r;
    end
  end
  // Remembers that a mode load has been seen
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mrd_done_r <= 1'b0;
    end else if (is_lmr) begin
      mrd_done_r <= 1'b1;
    end
  end

  // Burst length decode; single writes when write burst mode is set
  always_comb begin
    case (mode_q[sdi_pkg::MODE_BL_LSB +: 3])
      3'h0: bl_len = 9'h001;
      3'h1: bl_len = 9'h002;
      3'h2: bl_len = 9'h004;
      3'h3: bl_len = 9'h008;
      sdi_pkg::BL_FULL: bl_len = 9'h100;
      default: bl_len = 9'h001;
    endcase
  end

  // Current beat: new command or next location of running burst
  always_comb begin
    beat_v = bst_act_r;
    beat_wr = bst_wr_r;
    beat_bank = bst_bank_r;
    beat_start = bst_start_r;
    beat_i = bst_idx_r;
    beat_len = bst_len_r;
    if (is_acc) begin
      beat_v = 1'b1;
      beat_wr = (cmd == sdi_pkg::CMD_WR);
      beat_bank = bank;
      beat_start = addr[7:0];
      beat_i = 9'h000;
      beat_len = (beat_wr && mode_q[sdi_pkg::MODE_WB_POS]) ? 9'h001 : bl_len;
    end
    // Wrap inside the block; interleave only for short bursts
    mask = 8'(beat_len - 9'h001);
    offs = (mode_q[sdi_pkg::MODE_BT_POS] && beat_len != 9'h100) ?
           (beat_start ^ beat_i[7:0]) : (beat_start + beat_i[7:0]);
    beat_col = (beat_start & ~mask) | (offs & mask);
    idx = MEM_AW'({row_q[beat_bank], beat_bank, beat_col});
  end

  // Burst sequencing; a mode load stops it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_bank_r <= 2'h0;
      bst_start_r <= 8'h00;
      bst_idx_r <= 9'h000;
      bst_len_r <= 9'h001;
    end else if (is_lmr) begin
      bst_act_r <= 1'b0;
    end else if (beat_v) begin
      bst_act_r <= (beat_i + 9'h001) < beat_len;
      bst_wr_r <= beat_wr;
      bst_bank_r <= beat_bank;
      bst_start_r <= beat_start;
      bst_idx_r <= beat_i + 9'h001;
      bst_len_r <= beat_len;
    end
  end

  // Write beats store the 32-bit bus word
  always_ff @(posedge i_clk) begin
    if (beat_v && beat_wr && !is_lmr) begin
      mem_q[idx] <= bus.dq;
    end
  end

  // Read pipe: data appears after latency edges
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rp_v_r <= 3'h0;
      rp_d_r[0] <= '0;
      rp_d_r[1] <= '0;
      rp_d_r[2] <= '0;
    end else if (is_lmr) begin
      rp_v_r <= 3'h0;
    end else begin
      rp_v_r <= {rp_v_r[1:0], beat_v && !beat_wr};
      rp_d_r[0] <= mem_q[idx];
      rp_d_r[1] <= rp_d_r[0];
      rp_d_r[2] <= rp_d_r[1];
    end
  end

  // Output drivers, released by a mode load
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bus.mem_dq_oe <= 1'b0;
      bus.mem_dq_o <= '0;
    end else begin
      bus.mem_dq_oe <= rp_v_r[cl_sel] && !is_lmr;
      bus.mem_dq_o <= rp_d_r[cl_sel];
    end
  end
endmodule

// >>> dv/sdi_chk.sv
// Checker of command timing on the controller to memory link
module sdi_chk #(
  parameter int STARTUP_CYC = 1000
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [sdi_pkg::ADDR_W-1:0] row_column_address_bits,
  input wire logic ctrl_dq_oe,
  input wire logic mem_dq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cmd; // Command code on the pins
  logic idle; // Deselect or no-operation
  logic [15:0] cyc_r; // Cycles since reset, saturating
  logic [3:0] nref_r; // Refreshes seen since reset
  logic busy_r; // A real command was seen
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign idle = (cmd == sdi_pkg::CMD_NOP) || cs_n;
  // Track time, refreshes and the first real command
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cyc_r <= 16'h0000;
      nref_r <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      cyc_r <= (cyc_r == 16'hFFFF) ? cyc_r : cyc_r + 16'h0001;
      nref_r <= nref_r + {3'h0, cmd == sdi_pkg::CMD_REF};
      busy_r <= busy_r | ~idle;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Steps of the waits and accesses
  sequence quiet_s; idle; endsequence
  sequence rw_s; cmd == sdi_pkg::CMD_RD || cmd == sdi_pkg::CMD_WR; endsequence
  sequence hiz_s; !mem_dq_oe ##1 !mem_dq_oe; endsequence
  startup_quiet_a: assert property (cyc_r < STARTUP_CYC |-> quiet_s)
    else $error("command during start-up wait");
  cke_low_a: assert property (cyc_r == 0 |-> !clk_en)
    else $error("clock enable high at start");
  cke_up_a: assert property (cyc_r == STARTUP_CYC |-> clk_en)
    else $error("clock enable low after wait");
  first_pre_a: assert property (!busy_r && !idle |-> cmd == sdi_pkg::CMD_PRE &&
    row_column_address_bits[sdi_pkg::ALL_BANKS_POS]) else $error("first command not close-all");
  pre_wait_a: assert property (cmd == sdi_pkg::CMD_PRE |=> quiet_s)
    else $error("command inside precharge period");
  ref_wait_a: assert property (cmd == sdi_pkg::CMD_REF |=> quiet_s)
    else $error("command inside refresh period");
  ref_count_a: assert property (cmd == sdi_pkg::CMD_LMR |-> nref_r >= 2)
    else $error("mode load before two refreshes");
  lmr_bank_a: assert property (cmd == sdi_pkg::CMD_LMR |-> !bank_select_high &&
    !bank_select_low) else $error("mode load with bank bits set");
  lmr_hiz_a: assert property (cmd == sdi_pkg::CMD_LMR |-> hiz_s)
    else $error("data driven around mode load");
  mrd_wait_a: assert property (cmd == sdi_pkg::CMD_LMR |=> quiet_s)
    else $error("command inside mode load delay");
  act_rw_a: assert property (cmd == sdi_pkg::CMD_ACT |-> ##[1:4] rw_s)
    else $error("activate not followed by access");
  wr_data_a: assert property (cmd == sdi_pkg::CMD_WR |-> ctrl_dq_oe)
    else $error("write without data driven");
endmodule

// >>> dv/tb_sdram_powerup_init_and_addressing.sv
// Self-checking bench for the controller and memory pair
module tb_sdram_powerup_init_and_addressing;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SU = 20; // Shortened start-up wait
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic rq_v = 1'b0, rq_w = 1'b0, rq_rdy, rd_v, init_done, m_rdy, m_idle;
  logic [1:0] rq_bank = 2'h0;
  logic [10:0] rq_row = 11'h000, m_mode;
  logic [7:0] rq_col = 8'h00;
  logic [31:0] rq_wd = 32'h00000000, rd_d;
  logic [10:0] row_a[16]; // Saved rows
  logic [7:0] col_a[16]; // Saved columns
  logic [31:0] dat_a[16]; // Saved write data
  int bad_count = 0, n_compared = 0, seed = 32, j, k;
  sdi_if bus ();
  sdi_ctrl #(.STARTUP_CYC(SU)) i_sdi_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus),
    .i_req_valid(rq_v), .i_req_write(rq_w), .i_req_bank(rq_bank), .i_req_row(rq_row),
    .i_req_col(rq_col), .i_req_wdata(rq_wd), .o_req_ready(rq_rdy), .o_rd_valid(rd_v),
    .o_rd_data(rd_d), .o_init_done(init_done));
  sdi_mem i_sdi_mem (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus), .o_ready(m_rdy),
    .o_banks_idle(m_idle), .o_mode(m_mode));
  sdi_chk #(.STARTUP_CYC(SU)) i_sdi_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .clk_en(bus.clk_en), .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n),
    .we_n(bus.we_n), .bank_select_low(bus.bank_select_low),
    .bank_select_high(bus.bank_select_high),
    .row_column_address_bits(bus.row_column_address_bits),
    .ctrl_dq_oe(bus.ctrl_dq_oe), .mem_dq_oe(bus.mem_dq_oe));
  // Clock at 100 ns period
  always #50 i_clk = ~i_clk;
  // Column of entry n: top bits from the entry keep bank and column unique
  function automatic logic [7:0] col_of(input int n, input logic [7:0] r);
    return {n[3:2], r[5:0]};
  endfunction
  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print the verdict and end
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offer request n and hold it until taken
  task automatic push(input logic w, input int n);
    rq_v <= 1'b1;
    rq_w <= w;
    rq_bank <= n[1:0];
    rq_row <= row_a[n];
    rq_col <= col_a[n];
    rq_wd <= dat_a[n];
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (rq_rdy !== 1'b1 && k < 3000);
    check("req_taken", {31'h0, rq_rdy}, 32'h1);
  endtask
  // Cut a hang short
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    stop_test();
  end
  // Main sequence: fill during init, then read back in reverse
  initial begin
    for (j = 0; j < 16; j++) begin
      row_a[j] = 11'($random(seed));
      col_a[j] = col_of(j, 8'($random(seed)));
      dat_a[j] = $random(seed);
    end
    row_a[0] = 11'h000;
    col_a[0] = 8'h00;
    row_a[15] = 11'h7FF;
    col_a[15] = 8'hFF;
    dat_a[15] = 32'hFFFFFFFF;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    check("mode_default", {21'h0, m_mode}, {21'h0, sdi_pkg::MODE_DEFAULT});
    check("mem_ready_early", {31'h0, m_rdy}, 32'h0);
    check("init_early", {31'h0, init_done}, 32'h0);
    for (j = 0; j < 16; j++) push(1'b1, j);
    rq_v <= 1'b0;
    @(posedge i_clk);
    check("fifo_full", {31'h0, rq_rdy}, 32'h0);
    for (k = 0; k < 2000 && init_done !== 1'b1; k++) @(posedge i_clk);
    check("init_done", {31'h0, init_done}, 32'h1);
    @(posedge i_clk);
    check("mode_loaded", {21'h0, m_mode}, {21'h0, sdi_pkg::CTRL_MODE});
    check("mem_ready", {31'h0, m_rdy}, 32'h1);
    for (j = 15; j >= 0; j--) begin
      push(1'b0, j);
      rq_v <= 1'b0;
      k = 0;
      do begin
        @(posedge i_clk);
        k++;
      end while (rd_v !== 1'b1 && k < 3000);
      check("read_valid", {31'h0, rd_v}, 32'h1);
      check("read_data", rd_d, dat_a[j]);
    end
    repeat (10) @(posedge i_clk);
    check("banks_idle", {31'h0, m_idle}, 32'h1);
    stop_test();
  end
endmodule
